// File: core/gain_ramp.sv
// Linear ramp of the active proportional gain toward a target over a set duration.
// Assumes a one-cycle tick input at 1 ms and a duration given in milliseconds.
`timescale 1ns/10ps
module gain_ramp #(
    parameter int W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [W-1:0] target,
    input wire logic [W-1:0] duration,
    input wire logic [W-1:0] init_value,
    output logic [W-1:0] value,
    output logic busy
);
    logic [W-1:0] value_r, value_nxt;
    logic [W-1:0] start_r, start_nxt;
    logic [W-1:0] tgt_r, tgt_nxt;
    logic [W-1:0] step_r, step_nxt;
    logic loaded_r;

    wire target_changed = loaded_r && (target != tgt_r);
    wire ramp_done = (step_r >= duration) || (duration == '0);
    // Next point: start + (target - start) * (step + 1) / duration, done in signed wide arithmetic.
    wire signed [W+1:0] span = $signed({2'b00, tgt_r}) - $signed({2'b00, start_r});
    wire signed [2*W+2:0] scaled = span * $signed({1'b0, W'(step_r + 1'b1)});
    wire signed [2*W+2:0] part = (duration == '0) ? '0 : scaled / $signed({1'b0, duration});
    wire signed [2*W+2:0] point = $signed({{(W+3){1'b0}}, start_r}) + part;

    always_comb begin
        value_nxt = value_r;
        start_nxt = start_r;
        tgt_nxt = tgt_r;
        step_nxt = step_r;
        if (target_changed) begin
            // A new target restarts from wherever the gain stands now.
            start_nxt = value_r;
            tgt_nxt = target;
            step_nxt = '0;
        end else if (tick && !ramp_done) begin
            step_nxt = W'(step_r + 1'b1);
            value_nxt = (W'(step_r + 1'b1) >= duration) ? tgt_r : W'(point);
        end else if (ramp_done) begin
            value_nxt = tgt_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_r <= '0;
            start_r <= '0;
            tgt_r <= '0;
            step_r <= '0;
            loaded_r <= 1'b0;
        end else if (ce) begin
            if (!loaded_r) begin
                value_r <= init_value;
                start_r <= init_value;
                tgt_r <= init_value;
                step_r <= duration;
                loaded_r <= 1'b1;
            end else begin
                value_r <= value_nxt;
                start_r <= start_nxt;
                tgt_r <= tgt_nxt;
                step_r <= step_nxt;
            end
        end
    end

    assign value = value_r;
    assign busy = loaded_r && !ramp_done;
endmodule

// File: core/gain_sched_pkg.sv
// Package for the speed loop gain scheduler: register map, field layouts, reset values and timing.
// Assumes a 100 MHz control clock and 32-bit AXI4-Lite register access.
package gain_sched_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PGAIN1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ITIME1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PGAIN2 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_ITIME2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_COMP_LIMIT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FILT_LOW = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_FILT_HIGH = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_SWITCH_FREQ = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_FREQ_LIMITS = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_AOUT_CFG = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE_GAIN = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE_ITIME = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_COMP_OUT = 8'h38;

    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIN_FUNC_LSB = 8;
    localparam int CTRL_RAMP_INT_BIT = 16;
    localparam int CTRL_FF_EN_BIT = 17;

    // Analog output configuration fields.
    localparam int AOUT1_SRC_LSB = 0;
    localparam int AOUT2_SRC_LSB = 8;
    localparam int AOUT1_LVL_BIT = 16;
    localparam int AOUT2_LVL_BIT = 17;

    // Frequency limit fields.
    localparam int FMIN_LSB = 0;
    localparam int FMAX_LSB = 16;

    // Status fields.
    localparam int ST_GAINSEL_BIT = 0;
    localparam int ST_RAMPING_BIT = 1;
    localparam int ST_FILTSEL_BIT = 2;
    localparam int ST_INTEG_BIT = 3;
    localparam int ST_FF_BIT = 4;

    // Frequencies are held in 0.1 Hz units.
    localparam logic [15:0] FREQ_FILT_SPLIT = 16'h015E;
    localparam logic [15:0] SWITCH_FREQ_MAX = 16'h0FA0;
    localparam logic [7:0] DIN_GAIN_SWITCH_CODE = 8'h77;
    localparam logic [7:0] AOUT_SRC_OUT_FREQ = 8'h02;
    localparam logic [7:0] AOUT_SRC_MOTOR_SPEED = 8'h05;
    localparam logic AOUT_LEVEL_BIPOLAR = 1'b1;

    // Reset values of the settings.
    localparam logic [15:0] RST_PGAIN1 = 16'h0064;
    localparam logic [15:0] RST_ITIME1 = 16'h01F4;
    localparam logic [15:0] RST_PGAIN2 = 16'h0064;
    localparam logic [15:0] RST_ITIME2 = 16'h01F4;
    localparam logic [15:0] RST_COMP_LIMIT = 16'h0032;
    localparam logic [15:0] RST_FILT_LOW = 16'h0004;
    localparam logic [15:0] RST_FILT_HIGH = 16'h000A;
    localparam logic [15:0] RST_SWITCH_FREQ = 16'h0000;
    localparam logic [15:0] RST_FMIN = 16'h0005;
    localparam logic [15:0] RST_FMAX = 16'h0258;

    // Integral time is in ms; the ramp steps once per millisecond tick.
    localparam int CLK_HZ = 100_000_000;
    localparam int RAMP_TICK_NS = 1_000_000;
    localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / (1_000_000_000 / CLK_HZ);

    typedef enum logic [2:0] {
        MODE_VF,
        MODE_VF_PG,
        MODE_OLV1,
        MODE_FLUX_VECTOR,
        MODE_OLV2
    } ctrl_mode_t;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    typedef struct packed {
        logic [15:0] pgain;
        logic [15:0] itime;
    } gain_pair_t;

    typedef struct packed {
        logic [15:0] value;
        logic bipolar;
    } aout_t;

endpackage

// File: core/speed_loop_gain_scheduler.sv
// Speed loop gain scheduler: gain selection, gain ramping, V/f-with-feedback blending,
// filter constant choice, integrator gating and analog monitor routing.
// Assumes software sets parameters over AXI4-Lite and all status inputs are on aclk except the digital input.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - In vector modes, digital input with function 77 picks proportional gain 2 when on, gain 1 when off; integral time stays at set 1.
// - A configured digital gain switch overrides the speed threshold selection.
// - In vector modes, gain changes ramp linearly over integral time 1.
// - Open-loop vector 2 uses low filter constant to 35 Hz, high above.
// - Vector modes choose low or high speed gain pairs by switching frequency.
// - V/f with feedback interpolates gain and time between min and max frequency.
// - Source 2 routes output frequency to output one, 5 motor speed to output two.
// - Level select 1 makes an analog output bipolar, minus ten to ten volts.
// - Integrator runs while ramping only when integrate-during-ramp is enabled.
// - Feed-forward acts only in flux vector and open-loop vector 2 modes.
// - Switching frequency is held in 0.1 Hz, range 0 to 400.0, default 0.
// - Speed compensation is clamped to a percentage of maximum frequency, default 5.0.
module speed_loop_gain_scheduler
    import gain_sched_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic gain_switch_in,
    input wire logic [15:0] output_frequency,
    input wire logic signed [15:0] motor_speed,
    input wire logic accel_decel_active,
    input wire logic signed [15:0] comp_request,
    output gain_sched_pkg::gain_pair_t speed_regulator_gains,
    output logic [15:0] speed_filter_time,
    output logic integrator_enable,
    output logic feed_forward_enable,
    output logic signed [15:0] comp_limited,
    output gain_sched_pkg::aout_t analog_output_one,
    output gain_sched_pkg::aout_t analog_output_two
);
    import gain_sched_pkg::*;

    // Settings registers.
    logic [31:0] ctrl_r;
    logic [15:0] speed_prop_gain_one_r, speed_integral_time_one_r;
    logic [15:0] speed_prop_gain_two_r, speed_integral_time_two_r;
    logic [15:0] speed_comp_limit_r, speed_filter_time_low_r, speed_filter_time_high_r;
    logic [15:0] gain_switch_frequency_r, min_output_frequency_r, max_output_frequency_r;
    logic [31:0] aout_cfg_r;

    // Bus state.
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    // Digital input synchroniser: stage one feeds stage two only.
    logic din_s1_r, din_s2_r, din_s3_r, din_state_r;
    logic [$clog2(RAMP_TICK_CYCLES)-1:0] tick_cnt_r;
    logic tick_r;

    // Field views.
    wire ctrl_mode_t mode = ctrl_mode_t'(ctrl_r[CTRL_MODE_LSB +: 3]);
    wire [7:0] digital_input_function_select = ctrl_r[CTRL_DIN_FUNC_LSB +: 8];
    wire integrate_during_ramp_enable = ctrl_r[CTRL_RAMP_INT_BIT];
    wire ff_request = ctrl_r[CTRL_FF_EN_BIT];
    wire [7:0] analog_out1_source_select = aout_cfg_r[AOUT1_SRC_LSB +: 8];
    wire [7:0] analog_out2_source_select = aout_cfg_r[AOUT2_SRC_LSB +: 8];
    wire analog_out1_level_select = aout_cfg_r[AOUT1_LVL_BIT];
    wire analog_out2_level_select = aout_cfg_r[AOUT2_LVL_BIT];

    // Gain selection.
    wire vector_mode = (mode == MODE_FLUX_VECTOR) || (mode == MODE_OLV2);
    wire din_configured = (digital_input_function_select == DIN_GAIN_SWITCH_CODE);
    wire [15:0] speed_mag = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
    wire speed_sel_two = (gain_switch_frequency_r != 16'h0000) && (speed_mag < gain_switch_frequency_r);
    wire din_sel_two = din_state_r;
    wire sel_two = din_configured ? din_sel_two : speed_sel_two;
    wire [15:0] target_gain = sel_two ? speed_prop_gain_two_r : speed_prop_gain_one_r;
    wire [15:0] vec_itime = (!din_configured && speed_sel_two) ? speed_integral_time_two_r
                                                               : speed_integral_time_one_r;
    wire [15:0] ramp_gain;
    wire ramp_busy;

    gain_ramp #(.W(16)) u_ramp (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick_r),
        .target(target_gain),
        .duration(speed_integral_time_one_r),
        .init_value(RST_PGAIN1),
        .value(ramp_gain),
        .busy(ramp_busy)
    );

    // V/f with feedback: blend from set 2 at minimum frequency to set 1 at maximum frequency.
    wire [15:0] f_span = (max_output_frequency_r > min_output_frequency_r) ?
                         16'(max_output_frequency_r - min_output_frequency_r) : 16'h0001;
    wire [15:0] f_pos = (speed_mag <= min_output_frequency_r) ? 16'h0000 :
                        (speed_mag >= max_output_frequency_r) ? f_span : 16'(speed_mag - min_output_frequency_r);
    wire signed [17:0] dp = $signed({2'b00, speed_prop_gain_one_r}) - $signed({2'b00, speed_prop_gain_two_r});
    wire signed [17:0] di = $signed({2'b00, speed_integral_time_one_r}) - $signed({2'b00, speed_integral_time_two_r});
    wire signed [34:0] blend_p = $signed({2'b00, speed_prop_gain_two_r}) + dp * $signed({1'b0, f_pos}) / $signed({1'b0, f_span});
    wire signed [34:0] blend_i = $signed({2'b00, speed_integral_time_two_r}) + di * $signed({1'b0, f_pos}) / $signed({1'b0, f_span});

    gain_pair_t gains_nxt;
    always_comb begin
        if (mode == MODE_VF_PG) begin
            gains_nxt.pgain = blend_p[15:0];
            gains_nxt.itime = blend_i[15:0];
        end else if (vector_mode) begin
            gains_nxt.pgain = ramp_gain;
            gains_nxt.itime = vec_itime;
        end else begin
            gains_nxt.pgain = speed_prop_gain_one_r;
            gains_nxt.itime = speed_integral_time_one_r;
        end
    end

    // Filter constant: open-loop vector 2 splits at 35 Hz; other modes keep the low-speed constant.
    wire filt_high = (mode == MODE_OLV2) && (output_frequency > FREQ_FILT_SPLIT);
    wire [15:0] filt_nxt = filt_high ? speed_filter_time_high_r : speed_filter_time_low_r;

    // Compensation clamp: limit is percent times 0.1 of max frequency, so limit = fmax * pct / 1000.
    wire [31:0] lim_prod = max_output_frequency_r * speed_comp_limit_r;
    wire [15:0] comp_lim = 16'(lim_prod / 32'd1000);
    wire signed [16:0] lim_s = $signed({1'b0, comp_lim});
    wire signed [16:0] req_s = 17'(comp_request);
    wire signed [16:0] comp_nxt = (req_s > lim_s) ? lim_s : (req_s < -lim_s) ? -lim_s : req_s;

    wire integ_nxt = !accel_decel_active || integrate_during_ramp_enable;
    wire ff_nxt = ff_request && vector_mode;

    // Analog monitors; unassigned source codes show zero.
    wire [15:0] aout1_val = (analog_out1_source_select == AOUT_SRC_OUT_FREQ) ? output_frequency : 16'h0000;
    wire [15:0] aout2_val = (analog_out2_source_select == AOUT_SRC_MOTOR_SPEED) ? motor_speed : 16'h0000;
    wire aout1_bip = (analog_out1_level_select == AOUT_LEVEL_BIPOLAR);
    wire aout2_bip = (analog_out2_level_select == AOUT_LEVEL_BIPOLAR);

    // Bus decode.
    wire do_write = aw_held_r && w_held_r && !bvalid_r;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {27'h0, ff_nxt, integ_nxt, filt_high, ramp_busy, sel_two};
    wire [15:0] sw_freq_wr = (wdata_r[15:0] > SWITCH_FREQ_MAX) ? SWITCH_FREQ_MAX : wdata_r[15:0];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                old[8*b +: 8] = d[8*b +: 8];
            end
        end
        return old;
    endfunction

    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_CTRL: rd_mux = ctrl_r;
            OFF_PGAIN1: rd_mux = {16'h0, speed_prop_gain_one_r};
            OFF_ITIME1: rd_mux = {16'h0, speed_integral_time_one_r};
            OFF_PGAIN2: rd_mux = {16'h0, speed_prop_gain_two_r};
            OFF_ITIME2: rd_mux = {16'h0, speed_integral_time_two_r};
            OFF_COMP_LIMIT: rd_mux = {16'h0, speed_comp_limit_r};
            OFF_FILT_LOW: rd_mux = {16'h0, speed_filter_time_low_r};
            OFF_FILT_HIGH: rd_mux = {16'h0, speed_filter_time_high_r};
            OFF_SWITCH_FREQ: rd_mux = {16'h0, gain_switch_frequency_r};
            OFF_FREQ_LIMITS: rd_mux = {max_output_frequency_r, min_output_frequency_r};
            OFF_AOUT_CFG: rd_mux = aout_cfg_r;
            OFF_STATUS: rd_mux = status_word;
            OFF_ACTIVE_GAIN: rd_mux = {16'h0, speed_regulator_gains.pgain};
            OFF_ACTIVE_ITIME: rd_mux = {16'h0, speed_regulator_gains.itime};
            OFF_COMP_OUT: rd_mux = 32'(comp_limited);
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    wire wr_hit = (awaddr_r <= OFF_AOUT_CFG) && (awaddr_r[1:0] == 2'b00);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (do_read) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= {24'h0, 5'h0, 3'(MODE_FLUX_VECTOR)};
            speed_prop_gain_one_r <= RST_PGAIN1;
            speed_integral_time_one_r <= RST_ITIME1;
            speed_prop_gain_two_r <= RST_PGAIN2;
            speed_integral_time_two_r <= RST_ITIME2;
            speed_comp_limit_r <= RST_COMP_LIMIT;
            speed_filter_time_low_r <= RST_FILT_LOW;
            speed_filter_time_high_r <= RST_FILT_HIGH;
            gain_switch_frequency_r <= RST_SWITCH_FREQ;
            min_output_frequency_r <= RST_FMIN;
            max_output_frequency_r <= RST_FMAX;
            aout_cfg_r <= 32'h0;
        end else if (ce && do_write) begin
            case (awaddr_r)
                OFF_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
                OFF_PGAIN1: speed_prop_gain_one_r <= wdata_r[15:0];
                OFF_ITIME1: speed_integral_time_one_r <= wdata_r[15:0];
                OFF_PGAIN2: speed_prop_gain_two_r <= wdata_r[15:0];
                OFF_ITIME2: speed_integral_time_two_r <= wdata_r[15:0];
                OFF_COMP_LIMIT: speed_comp_limit_r <= wdata_r[15:0];
                OFF_FILT_LOW: speed_filter_time_low_r <= wdata_r[15:0];
                OFF_FILT_HIGH: speed_filter_time_high_r <= wdata_r[15:0];
                OFF_SWITCH_FREQ: gain_switch_frequency_r <= sw_freq_wr;
                OFF_FREQ_LIMITS: begin
                    min_output_frequency_r <= wdata_r[FMIN_LSB +: 16];
                    max_output_frequency_r <= wdata_r[FMAX_LSB +: 16];
                end
                OFF_AOUT_CFG: aout_cfg_r <= merge(aout_cfg_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            din_s3_r <= 1'b0;
            din_state_r <= 1'b0;
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
            speed_regulator_gains <= '0;
            speed_filter_time <= '0;
            integrator_enable <= 1'b0;
            feed_forward_enable <= 1'b0;
            comp_limited <= '0;
            analog_output_one <= '0;
            analog_output_two <= '0;
        end else if (ce) begin
            din_s1_r <= gain_switch_in;
            din_s2_r <= din_s1_r;
            din_s3_r <= din_s2_r;
            if (din_s2_r == din_s3_r) begin
                din_state_r <= din_s3_r;
            end
            tick_r <= (tick_cnt_r == '0);
            tick_cnt_r <= (tick_cnt_r == '0) ? ($clog2(RAMP_TICK_CYCLES))'(RAMP_TICK_CYCLES - 1) : tick_cnt_r - 1'b1;
            speed_regulator_gains <= gains_nxt;
            speed_filter_time <= filt_nxt;
            integrator_enable <= integ_nxt;
            feed_forward_enable <= ff_nxt;
            comp_limited <= comp_nxt[15:0];
            analog_output_one <= '{value: aout1_val, bipolar: aout1_bip};
            analog_output_two <= '{value: aout2_val, bipolar: aout2_bip};
        end
    end

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// File: test/motor_encoder_model.sv
// Motor with speed encoder: encoder speed tracks the drive's output frequency.
// Assumes the frequency is in 0.1 Hz counts; a slow motor closes one count a cycle.
`timescale 1ns/10ps
module motor_encoder_model #(
    parameter bit PROMPT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] output_frequency,
    output logic signed [15:0] motor_speed
);
    always @(posedge aclk)
        if (!aresetn)
            motor_speed <= 16'sh0000;
        else if (PROMPT || motor_speed == $signed(output_frequency))
            motor_speed <= $signed(output_frequency);
        else
            motor_speed <= motor_speed + ((motor_speed < $signed(output_frequency)) ? 16'sh0001 : 16'shFFFF);
endmodule

// File: test/speed_loop_gain_scheduler_sva.sv
// Checker for the scheduler's bus handshakes and integrator gating.
// Bound to the top module and sees its ports only.
`timescale 1ns/10ps
module gain_sched_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic accel_decel_active,
    input wire logic integrator_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_taken; ce && s_axi_arvalid && s_axi_arready; endsequence
    sequence rd_held; s_axi_rvalid && !s_axi_rready; endsequence
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
    chk_read_hold: assert property (rd_held |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    chk_read_end: assert property (ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read stuck");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_write_end: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write stuck");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
    chk_integ_idle: assert property (ce && !accel_decel_active |=> integrator_enable)
        else $error("integrator held off at steady speed");
endmodule
bind speed_loop_gain_scheduler gain_sched_sva chk_i (.*);

// File: test/speed_loop_gain_scheduler_tb_top.sv
// Self-checking bench for the speed loop gain scheduler.
// Assumes the bus is the only way to the settings; a motor model closes the speed loop.
`timescale 1ns/10ps
module speed_loop_gain_scheduler_tb_top;
    import gain_sched_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h8DE6;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, integrator_enable, feed_forward_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic gain_switch_in = 1'b0, accel_decel_active = 1'b0;
    logic [15:0] output_frequency = 16'h0000, speed_filter_time;
    logic signed [15:0] comp_request = 16'sh0000, comp_limited, motor_speed;
    gain_pair_t speed_regulator_gains;
    aout_t analog_output_one, analog_output_two;
    int err_total = 0, checked = 0, lim;
    speed_loop_gain_scheduler dut (.*);
    motor_encoder_model motor (.*);
    always #5 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
        end while (!s_axi_rvalid);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        rdr(a);
        chk(rd, x);
    endtask
    task automatic settle;
        repeat (8) @(posedge aclk);
    endtask
    task automatic selchk(input logic [15:0] sf, input logic [15:0] f, input logic [31:0] c, input logic g, input logic x);
        wr(OFF_SWITCH_FREQ, {16'h0, sf});
        wr(OFF_CTRL, c);
        output_frequency <= f;
        gain_switch_in <= g;
        settle;
        rdr(OFF_STATUS);
        chk(rd[0], x);
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(OFF_SWITCH_FREQ, 32'h0);
        wr(OFF_SWITCH_FREQ, 32'h1388);
        rdchk(OFF_SWITCH_FREQ, {16'h0, SWITCH_FREQ_MAX});
        rdchk(OFF_COMP_LIMIT, {16'h0, RST_COMP_LIMIT});
        rdr(8'h40);
        chk(rr, RESP_SLVERR);
        lim = int'(RST_FMAX) * int'(RST_COMP_LIMIT) / 1000;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            comp_request <= seed[15:0];
            settle;
            chk(32'(comp_limited), $signed(seed[15:0]) > lim ? lim : $signed(seed[15:0]) < -lim ? -lim : 32'($signed(seed[15:0])));
        end
        output_frequency <= 16'h01F4;
        for (int l = 1; l >= 0; l--) begin
            wr(OFF_AOUT_CFG, {14'h0, l[0], l[0], 16'h0502});
            settle;
            chk(analog_output_one, {16'h01F4, l[0]});
            chk(analog_output_two, {16'h01F4, l[0]});
        end
        wr(OFF_CTRL, 32'h4);
        for (int f = 350; f <= 351; f++) begin
            output_frequency <= 16'(f);
            settle;
            chk(speed_filter_time, f > 350 ? RST_FILT_HIGH : RST_FILT_LOW);
        end
        accel_decel_active <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            wr(OFF_CTRL, 32'h3 | (32'(b) << 16));
            settle;
            chk(integrator_enable, b[0]);
        end
        for (int m = 0; m < 5; m++) begin
            wr(OFF_CTRL, 32'h0002_0000 | 32'(m));
            settle;
            chk(feed_forward_enable, m == 3 || m == 4);
        end
        accel_decel_active <= 1'b0;
        wr(OFF_ITIME2, 32'h12C);
        selchk(16'h64, 16'h32, 32'h3, 1'b0, 1'b1);
        rdchk(OFF_ACTIVE_ITIME, 32'h12C);
        selchk(16'h64, 16'hC8, 32'h3, 1'b0, 1'b0);
        selchk(16'h0, 16'h32, 32'h3, 1'b0, 1'b0);
        selchk(16'h64, 16'h32, 32'h7703, 1'b0, 1'b0);
        wr(OFF_PGAIN2, 32'hC8);
        selchk(16'h64, 16'hC8, 32'h7703, 1'b1, 1'b1);
        chk(rd[1], 1'b1);
        rdchk(OFF_ACTIVE_GAIN, {16'h0, RST_PGAIN1});
        selchk(16'h64, 16'hC8, 32'h7703, 1'b0, 1'b0);
        rdchk(OFF_ACTIVE_GAIN, {16'h0, RST_PGAIN1});
        selchk(16'h64, 16'h7C, 32'h1, 1'b0, 1'b0);
        rdchk(OFF_ACTIVE_GAIN, 200 - 100 * (124 - RST_FMIN) / (RST_FMAX - RST_FMIN));
        complete_run;
    end
endmodule
